// file: verilog/olt_top.v
// Loop-back test control, result counters and AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`include "olt_map.vh"

// Operation
// - Writing one to bit 4 resets sub-layer, MACs and fabric; self-clears.
// - Bit 3 one permits remote command access; zero refuses it; resets zero.
// - Terminal side with bit 2: fiber or center link loss silences copper.
// - Center side ignores bit 2; its reset value is the strap level.
// - Bit 1 floats the fiber transmit output; clearing restores transmit.
// - Writing one to bit 0 resets both PHYs, self-clears, keeps registers.
// - Center side powers bit 0 up as one until index 0x40 is written.
// - Writing zero to the count register clears the result counters.
// - Center side count from one to one hundred sends that many frames.
// - Count register resets to seven frames.
// - Codes 00, 01, 04 give 55AA frames of listed size and address.
// - Codes 10, 40, 80 long; 02, 08, 20 short variants of patterns.
// - Unicast destination is station address with last byte plus frame number; broadcast codes send to all-ones.
// - Source is station address; type/length is 0x0800.
// - Center side counts returned frames carrying a check error.
// - Center side counts frames not returned before the timeout.
module olt_top #(
  parameter REPLY_TIMEOUT_CYC = `OLT_REPLY_TIMEOUT_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire center_side_mode,
  input wire link_pass_strap,
  input wire fiber_link_down,
  input wire center_copper_link_down,
  input wire reply_valid,
  input wire reply_bad_check,
  input wire tx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  output wire tx_last,
  output reg sublayer_reset,
  output reg phy_reset,
  output reg remote_command_enable,
  output reg copper_tx_disable,
  output reg copper_led_off,
  output reg fiber_tx_oe_n,
  output reg irq
);

localparam ST_IDLE = 2'd0;
localparam ST_SEND = 2'd1;
localparam ST_WAIT = 2'd2;

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
reg [3:0] pin_meta;
reg [3:0] pin_sync;
wire center_mode = pin_sync[0];
wire strap_level = pin_sync[1];
wire fiber_down = pin_sync[2];
wire copper_down = pin_sync[3];

// Two stages for every pin input
always @(posedge aclk) begin
  pin_meta <= {center_copper_link_down, fiber_link_down, link_pass_strap,
               center_side_mode};
  pin_sync <= pin_meta;
end

// ----------------------------------------------------------------------
// Register state
// ----------------------------------------------------------------------
reg remote_en;
reg link_pass_en;
reg fiber_tx_dis;
reg phy_hold;
reg [7:0] count_setup;
reg [7:0] pattern_sel;
reg [47:0] station;
reg [`OLT_IRQ_WIDTH-1:0] irq_status;
reg [`OLT_IRQ_WIDTH-1:0] irq_mask;
reg [`OLT_IRQ_WIDTH-1:0] irq_event;

// Write channel capture
reg aw_held;
reg w_held;
reg [7:0] aw_idx;
reg [7:0] w_byte;
reg w_lane0;
wire wr_fire = aw_held && w_held && !s_axi_bvalid;
wire wr_en = wr_fire && w_lane0;
wire [7:0] rd_idx = s_axi_araddr[9:2];
wire sw_reset_wr = wr_en && aw_idx == `OLT_IDX_MAINT_CTRL &&
                   w_byte[`OLT_BIT_SW_RESET];
wire count_wr = wr_en && aw_idx == `OLT_IDX_COUNT_SETUP;

// Mapped index check
function mapped;
  input [7:0] idx;
  begin
    mapped = idx == `OLT_IDX_MODE_SETUP || idx == `OLT_IDX_MAINT_CTRL ||
             (idx >= `OLT_IDX_COUNT_SETUP && idx <= `OLT_IDX_REPLY_LOST) ||
             (idx >= `OLT_IDX_STATION_0 && idx <= `OLT_IDX_STATION_5) ||
             idx == `OLT_IDX_IRQ_STATUS || idx == `OLT_IDX_IRQ_MASK;
  end
endfunction

// ----------------------------------------------------------------------
// AXI4-Lite write path
// ----------------------------------------------------------------------
always @(posedge aclk) begin
  if (!aresetn) begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_idx <= 8'h00;
    w_byte <= 8'h00;
    w_lane0 <= 1'b0;
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'b00;
  end else begin
    s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
    s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_idx) ? 2'b00 : 2'b10;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------------
// Loop-back sequencer state
// ----------------------------------------------------------------------
reg [1:0] state;
reg [7:0] frames_left;
reg [7:0] da_last;
reg [15:0] wait_cnt;
reg gen_start;
wire gen_done;
wire [7:0] bad_count;
wire [7:0] lost_count;
wire hold_rst = !aresetn || sublayer_reset;
wire clear_results = count_wr && w_byte == 8'h00;
wire reply_ok = state == ST_WAIT && reply_valid;
wire reply_timeout = state == ST_WAIT && !reply_valid &&
                     wait_cnt == REPLY_TIMEOUT_CYC[15:0] - 16'd1;
wire start_run = count_wr && center_mode && state == ST_IDLE &&
                 w_byte != 8'h00 && w_byte <= `OLT_MAX_FRAMES;

// Sequence frames: send, then wait for a return or the timeout
always @(posedge aclk) begin
  irq_event <= {`OLT_IRQ_WIDTH{1'b0}};
  gen_start <= 1'b0;
  if (hold_rst) begin
    state <= ST_IDLE;
    frames_left <= 8'h00;
    da_last <= 8'h00;
    wait_cnt <= 16'd0;
  end else begin
    case (state)
      ST_IDLE: begin
        if (start_run) begin
          frames_left <= w_byte;
          da_last <= station[7:0] + 8'h01;
          gen_start <= 1'b1;
          state <= ST_SEND;
        end
      end
      ST_SEND: begin
        wait_cnt <= 16'd0;
        if (gen_done) begin
          state <= ST_WAIT;
        end
      end
      ST_WAIT: begin
        wait_cnt <= wait_cnt + 16'd1;
        if (reply_ok || reply_timeout) begin
          irq_event[`OLT_IRQ_BAD_CHECK] <= reply_ok && reply_bad_check;
          irq_event[`OLT_IRQ_REPLY_LOST] <= reply_timeout;
          if (frames_left == 8'h01) begin
            irq_event[`OLT_IRQ_RUN_DONE] <= 1'b1;
            frames_left <= 8'h00;
            state <= ST_IDLE;
          end else begin
            frames_left <= frames_left - 8'h01;
            da_last <= da_last + 8'h01;
            gen_start <= 1'b1;
            state <= ST_SEND;
          end
        end
      end
      default: begin
        state <= ST_IDLE;
      end
    endcase
  end
end

// Frame stream toward the fiber MAC
olt_frame_gen u_gen (
  .aclk(aclk),
  .hold_rst(hold_rst),
  .start(gen_start),
  .station(station),
  .da_last(da_last),
  .pattern(pattern_sel),
  .tx_ready(tx_ready),
  .tx_data(tx_data),
  .tx_valid(tx_valid),
  .tx_last(tx_last),
  .done(gen_done)
);

// Result counters, cleared by a zero count write or sub-layer reset
olt_sat_counter u_bad (
  .aclk(aclk),
  .clear(hold_rst || clear_results),
  .bump(reply_ok && reply_bad_check),
  .count(bad_count)
);

olt_sat_counter u_lost (
  .aclk(aclk),
  .clear(hold_rst || clear_results),
  .bump(reply_timeout),
  .count(lost_count)
);

// ----------------------------------------------------------------------
// Control and setup registers
// ----------------------------------------------------------------------
always @(posedge aclk) begin
  if (!aresetn) begin
    remote_en <= 1'b0;
    link_pass_en <= strap_level;
    fiber_tx_dis <= 1'b0;
    phy_hold <= center_mode;
    count_setup <= `OLT_RST_COUNT_SETUP;
    pattern_sel <= `OLT_RST_PATTERN_SEL;
    station <= 48'h000000000000;
    irq_mask <= {`OLT_IRQ_WIDTH{1'b0}};
    irq_status <= {`OLT_IRQ_WIDTH{1'b0}};
  end else begin
    // Sticky status; a new event beats a clear in the same cycle
    irq_status <= (irq_status & ~((wr_en &&
                   aw_idx == `OLT_IDX_IRQ_STATUS) ?
                   w_byte[`OLT_IRQ_WIDTH-1:0] : {`OLT_IRQ_WIDTH{1'b0}}))
                  | irq_event;
    if (wr_en && aw_idx == `OLT_IDX_MODE_SETUP) begin
      phy_hold <= 1'b0;
    end
    if (wr_en) begin
      case (aw_idx)
        `OLT_IDX_MAINT_CTRL: begin
          remote_en <= w_byte[`OLT_BIT_REMOTE_EN];
          link_pass_en <= w_byte[`OLT_BIT_LINK_PASS];
          fiber_tx_dis <= w_byte[`OLT_BIT_FIBER_TX_DIS];
        end
        `OLT_IDX_COUNT_SETUP: count_setup <= w_byte;
        `OLT_IDX_PATTERN_SEL: pattern_sel <= w_byte;
        `OLT_IDX_IRQ_MASK: irq_mask <= w_byte[`OLT_IRQ_WIDTH-1:0];
        default: begin
          if (aw_idx >= `OLT_IDX_STATION_0 &&
              aw_idx <= `OLT_IDX_STATION_5) begin
            station[8'd47 - {aw_idx[2:0] - 3'd2, 3'b000} -: 8] <= w_byte;
          end
        end
      endcase
    end
  end
end

// ----------------------------------------------------------------------
// Output drive
// ----------------------------------------------------------------------
wire phy_pulse = wr_en && aw_idx == `OLT_IDX_MAINT_CTRL &&
                 w_byte[`OLT_BIT_PHY_RESET];
wire silence = !center_mode && link_pass_en &&
               (fiber_down || copper_down);

always @(posedge aclk) begin
  if (!aresetn) begin
    sublayer_reset <= 1'b0;
    phy_reset <= 1'b0;
    remote_command_enable <= 1'b0;
    copper_tx_disable <= 1'b0;
    copper_led_off <= 1'b0;
    fiber_tx_oe_n <= 1'b0;
    irq <= 1'b0;
  end else begin
    sublayer_reset <= sw_reset_wr;
    phy_reset <= phy_pulse || phy_hold;
    remote_command_enable <= remote_en;
    copper_tx_disable <= silence;
    copper_led_off <= silence;
    fiber_tx_oe_n <= fiber_tx_dis;
    irq <= |(irq_status & irq_mask);
  end
end

// ----------------------------------------------------------------------
// AXI4-Lite read path
// ----------------------------------------------------------------------
reg [7:0] rd_byte;

// Read multiplexer; unmapped indices read zero
always @* begin
  rd_byte = 8'h00;
  case (rd_idx)
    `OLT_IDX_MAINT_CTRL: rd_byte = {5'b00000, remote_en, link_pass_en,
                                    fiber_tx_dis} << 1 | {7'd0, phy_hold};
    `OLT_IDX_COUNT_SETUP: rd_byte = count_setup;
    `OLT_IDX_PATTERN_SEL: rd_byte = pattern_sel;
    `OLT_IDX_BAD_CHECK: rd_byte = bad_count;
    `OLT_IDX_REPLY_LOST: rd_byte = lost_count;
    `OLT_IDX_IRQ_STATUS: rd_byte = {5'b00000, irq_status};
    `OLT_IDX_IRQ_MASK: rd_byte = {5'b00000, irq_mask};
    default: begin
      if (rd_idx >= `OLT_IDX_STATION_0 && rd_idx <= `OLT_IDX_STATION_5) begin
        rd_byte = station[8'd47 - {rd_idx[2:0] - 3'd2, 3'b000} -: 8];
      end
    end
  endcase
end

// Address taken and answered one cycle later
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= 2'b00;
  end else begin
    s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= mapped(rd_idx) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

endmodule

// file: pkg/olt_map.vh
// Register map, field positions, reset values and timing of the loop-back block
`ifndef OLT_MAP_VH
`define OLT_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define OLT_IDX_MODE_SETUP 8'h40
`define OLT_IDX_MAINT_CTRL 8'h43
`define OLT_IDX_COUNT_SETUP 8'h44
`define OLT_IDX_PATTERN_SEL 8'h45
`define OLT_IDX_BAD_CHECK 8'h46
`define OLT_IDX_REPLY_LOST 8'h47
`define OLT_IDX_STATION_0 8'h52
`define OLT_IDX_STATION_5 8'h57
`define OLT_IDX_IRQ_STATUS 8'h60
`define OLT_IDX_IRQ_MASK 8'h61

// ----------------------------------------------------------------------
// Maintenance control fields
// ----------------------------------------------------------------------
`define OLT_BIT_SW_RESET 4
`define OLT_BIT_REMOTE_EN 3
`define OLT_BIT_LINK_PASS 2
`define OLT_BIT_FIBER_TX_DIS 1
`define OLT_BIT_PHY_RESET 0

// Interrupt status fields
`define OLT_IRQ_RUN_DONE 0
`define OLT_IRQ_BAD_CHECK 1
`define OLT_IRQ_REPLY_LOST 2
`define OLT_IRQ_WIDTH 3

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define OLT_RST_COUNT_SETUP 8'h07
`define OLT_RST_PATTERN_SEL 8'h00
`define OLT_MAX_FRAMES 8'h64
`define OLT_COUNT_MAX 8'hFF

// Pattern codes
`define OLT_PAT_64_UNI_55AA 8'h00
`define OLT_PAT_1518_UNI_55AA 8'h01
`define OLT_PAT_64_UNI_55AA_B 8'h02
`define OLT_PAT_1518_BC_55AA 8'h04
`define OLT_PAT_64_BC_55AA 8'h08
`define OLT_PAT_1518_UNI_0F0F 8'h10
`define OLT_PAT_64_UNI_0F0F 8'h20
`define OLT_PAT_1518_BC_0F0F 8'h40
`define OLT_PAT_1518_BC_FF00 8'h80

// Frame layout: lengths exclude the four check bytes added by the MAC
`define OLT_SHORT_LEN 11'd60
`define OLT_LONG_LEN 11'd1514
`define OLT_TYPE_LENGTH 16'h0800
`define OLT_HDR_LEN 11'd14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OLT_CLK_MHZ 10
`define OLT_REPLY_TIMEOUT_US 1000
`define OLT_REPLY_TIMEOUT_CYC (`OLT_REPLY_TIMEOUT_US * `OLT_CLK_MHZ)

`endif

// file: verilog/olt_sat_counter.v
// Eight-bit result counter that sticks at its top value
`include "olt_map.vh"
module olt_sat_counter (
  input wire aclk,
  input wire clear,
  input wire bump,
  output reg [7:0] count
);

// Clear has priority; sticks at the top value
always @(posedge aclk) begin
  if (clear) begin
    count <= 8'h00;
  end else if (bump && count != `OLT_COUNT_MAX) begin
    count <= count + 8'h01;
  end
end

endmodule

// file: verilog/olt_frame_gen.v
// Byte stream generator for one loop-back test frame
`include "olt_map.vh"
module olt_frame_gen (
  input wire aclk,
  input wire hold_rst,
  input wire start,
  input wire [47:0] station,
  input wire [7:0] da_last,
  input wire [7:0] pattern,
  input wire tx_ready,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_last,
  output reg done
);

reg [10:0] idx;
reg [10:0] len;
reg bcast;
reg [15:0] fill;
reg [7:0] next_byte;
reg [47:0] da;
reg load;
wire [15:0] type_len = `OLT_TYPE_LENGTH;

// ----------------------------------------------------------------------
// Byte selection
// ----------------------------------------------------------------------
// Header first, then the two-byte fill pattern repeated
always @* begin
  da = bcast ? 48'hFFFFFFFFFFFF : {station[47:8], da_last};
  next_byte = idx[0] ? fill[7:0] : fill[15:8];
  if (idx < 11'd6) begin
    next_byte = da[8'd47 - {idx[2:0], 3'b000} -: 8];
  end else if (idx < 11'd12) begin
    next_byte = station[8'd95 - {idx[3:0], 3'b000} -: 8];
  end else if (idx == 11'd12) begin
    next_byte = type_len[15:8];
  end else if (idx == 11'd13) begin
    next_byte = type_len[7:0];
  end
end

// ----------------------------------------------------------------------
// Pattern decode and stream sequencing
// ----------------------------------------------------------------------
always @(posedge aclk) begin
  done <= 1'b0;
  load <= 1'b0;
  if (hold_rst) begin
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    tx_data <= 8'h00;
    idx <= 11'd0;
    len <= `OLT_SHORT_LEN;
    bcast <= 1'b0;
    fill <= 16'h55AA;
  end else if (start && !tx_valid) begin
    idx <= 11'd0;
    case (pattern)
      `OLT_PAT_1518_UNI_55AA: begin
        len <= `OLT_LONG_LEN; bcast <= 1'b0; fill <= 16'h55AA;
      end
      `OLT_PAT_1518_BC_55AA: begin
        len <= `OLT_LONG_LEN; bcast <= 1'b1; fill <= 16'h55AA;
      end
      `OLT_PAT_64_BC_55AA: begin
        len <= `OLT_SHORT_LEN; bcast <= 1'b1; fill <= 16'h55AA;
      end
      `OLT_PAT_1518_UNI_0F0F: begin
        len <= `OLT_LONG_LEN; bcast <= 1'b0; fill <= 16'h0F0F;
      end
      `OLT_PAT_64_UNI_0F0F: begin
        len <= `OLT_SHORT_LEN; bcast <= 1'b0; fill <= 16'h0F0F;
      end
      `OLT_PAT_1518_BC_0F0F: begin
        len <= `OLT_LONG_LEN; bcast <= 1'b1; fill <= 16'h0F0F;
      end
      `OLT_PAT_1518_BC_FF00: begin
        len <= `OLT_LONG_LEN; bcast <= 1'b1; fill <= 16'hFF00;
      end
      default: begin
        len <= `OLT_SHORT_LEN; bcast <= 1'b0; fill <= 16'h55AA;
      end
    endcase
    load <= 1'b1;
    tx_last <= 1'b0;
  end else if (load) begin
    tx_valid <= 1'b1;
    tx_data <= next_byte; // Load first byte after decode settles
    idx <= 11'd1;
  end else if (tx_valid && tx_ready) begin
    if (tx_last) begin
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      done <= 1'b1;
      idx <= 11'd0;
    end else begin
      tx_data <= next_byte;
      tx_last <= (idx == len - 11'd1);
      idx <= idx + 11'd1;
    end
  end
end

endmodule

// file: test/olt_props.sv
// Port-level assertions for the loop-back control block
module olt_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire center_side_mode,
  input wire tx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  input wire sublayer_reset,
  input wire phy_reset,
  input wire remote_command_enable,
  input wire copper_tx_disable,
  input wire copper_led_off,
  input wire fiber_tx_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Mode held long enough to pass the pin synchronisers
  sequence center_held;
    center_side_mode [*4];
  endsequence
  sequence term_held;
    !center_side_mode [*4];
  endsequence
  sequence frame_end;
    tx_valid && tx_ready && tx_last;
  endsequence
  // Fiber float and remote enable outputs move only around a register write
  fiber_float_a: assert property ($changed(fiber_tx_oe_n) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("fiber enable moved");
  remote_en_a: assert property ($changed(remote_command_enable) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("remote enable moved");
  // Self-clearing resets are single pulses
  sub_pulse_a: assert property (sublayer_reset |=> !sublayer_reset)
    else $error("sub-layer reset longer than one cycle");
  phy_pulse_a: assert property (term_held ##0 phy_reset |=> !phy_reset)
    else $error("phy reset longer than one cycle");
  // Centre side ignores the enhanced link-pass bit
  center_link_a: assert property (center_held |->
    !copper_tx_disable && !copper_led_off) else $error("centre copper off");
  // Stream bytes stand until taken, one frame in flight
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_last)) else $error("byte not held");
  frame_gap_a: assert property (frame_end |=> !tx_valid)
    else $error("next frame before reply");
  term_quiet_a: assert property (term_held |-> !tx_valid)
    else $error("terminal side sent a frame");
endmodule

bind olt_top olt_props u_olt_props (.aclk, .aresetn, .s_axi_bvalid,
  .center_side_mode, .tx_ready, .tx_data, .tx_valid, .tx_last,
  .sublayer_reset, .phy_reset, .remote_command_enable, .copper_tx_disable,
  .copper_led_off, .fiber_tx_oe_n);

// file: test/olt_far_end.sv
// Far-end converter model: sinks test frames and answers each one unless reply_mode is 2
module olt_far_end (
  input wire aclk,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  input wire [1:0] reply_mode,
  input wire stall,
  output logic tx_ready,
  output logic reply_valid,
  output logic reply_bad_check,
  output int frames,
  output int frame_len,
  output logic [0:15][7:0] hdr
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  int gap = 0;
  logic ph = 0;
  initial begin
    tx_ready = 0;
    reply_valid = 0;
    reply_bad_check = 0;
    frames = 0;
    frame_len = 0;
  end
  // Mode 0 good reply, 1 bad check, 2 frame lost; unqualified flag toggles
  always @(posedge aclk) begin
    ph <= !ph;
    tx_ready <= stall ? ph : 1'b1;
    reply_valid <= 1'b0;
    reply_bad_check <= !reply_bad_check;
    if (gap > 0) gap <= gap - 1;
    if (gap == 1 && reply_mode != 2'd2) begin
      reply_valid <= 1'b1;
      reply_bad_check <= reply_mode == 2'd1;
    end
    if (tx_valid && tx_ready) begin
      if (pos < 16) hdr[pos] <= tx_data;
      pos <= tx_last ? 0 : pos + 1;
      if (tx_last) begin
        frame_len <= pos + 1;
        frames <= frames + 1;
        gap <= 3;
      end
    end
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the loop-back control block
`include "olt_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTRL = `OLT_IDX_MAINT_CTRL;
  localparam logic [7:0] PAT = `OLT_IDX_PATTERN_SEL;
  localparam logic [7:0] BAD = `OLT_IDX_BAD_CHECK;
  localparam logic [7:0] LOST = `OLT_IDX_REPLY_LOST;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, stall = 0;
  logic center_side_mode = 1, link_pass_strap = 0;
  logic fiber_link_down = 0, center_copper_link_down = 0;
  logic [1:0] reply_mode = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire reply_valid, reply_bad_check, tx_ready, tx_valid, tx_last;
  wire [7:0] tx_data;
  wire sublayer_reset, phy_reset, remote_command_enable, irq;
  wire copper_tx_disable, copper_led_off, fiber_tx_oe_n;
  int frames, frame_len, n_fail = 0, total_checks = 0;
  logic [0:15][7:0] hdr;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic saw_phy = 0, saw_sub = 0;
  always #50 aclk = !aclk;
  // Catch the one-cycle reset pulses
  always @(posedge aclk) begin
    if (phy_reset) saw_phy <= 1;
    if (sublayer_reset) saw_sub <= 1;
  end
  olt_top #(.REPLY_TIMEOUT_CYC(50)) u_olt_top (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .center_side_mode, .link_pass_strap, .fiber_link_down,
    .center_copper_link_down, .reply_valid, .reply_bad_check, .tx_ready,
    .tx_data, .tx_valid, .tx_last, .sublayer_reset, .phy_reset,
    .remote_command_enable, .copper_tx_disable, .copper_led_off,
    .fiber_tx_oe_n, .irq);
  olt_far_end u_olt_far_end (.aclk, .tx_data, .tx_valid, .tx_last,
    .reply_mode, .stall, .tx_ready, .reply_valid, .reply_bad_check, .frames,
    .frame_len, .hdr);
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Register write: address and data together, each released when taken
  task automatic wr(input logic [7:0] ix, input logic [7:0] d,
                    input logic [1:0] er = 2'b00);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      k++;
    end while (s_axi_bvalid !== 1 && k < 50);
    s_axi_bready <= 0;
    guard(k, 50);
    `CHK(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] ix);
    int k;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, ix, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      k++;
    end while (s_axi_rvalid !== 1 && k < 50);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 0;
    guard(k, 50);
  endtask
  task automatic chk_rd(input logic [7:0] ix, input logic [7:0] e);
    rd(ix);
    `CHK(rd_data, {24'h0, e});
  endtask
  task automatic do_reset(input logic c, input logic s);
    aresetn <= 0;
    center_side_mode <= c;
    link_pass_strap <= s;
    cyc(4);
    aresetn <= 1;
  endtask
  // Start a run and wait for the expected frames plus the last reply window
  task automatic run(input logic [7:0] n, input int ne);
    int f0;
    int k;
    f0 = frames;
    wr(`OLT_IDX_COUNT_SETUP, n);
    for (k = 0; k < ne * 1700 + 9 && frames != f0 + ne; k++) cyc(1);
    guard(k, ne * 1700 + 9);
    cyc(80);
    `CHK(frames - f0, ne);
  endtask
  task automatic t_power();
    do_reset(1, 1);
    cyc(2);
    `CHK(phy_reset, 1'b1);
    chk_rd(CTRL, 8'h05);
    chk_rd(`OLT_IDX_COUNT_SETUP, 8'h07);
    chk_rd(PAT, 8'h00);
    chk_rd(BAD, 8'h00);
    chk_rd(LOST, 8'h00);
    wr(`OLT_IDX_MODE_SETUP, 8'h00);
    cyc(3);
    `CHK(phy_reset, 1'b0);
    chk_rd(CTRL, 8'h04);
    wr(8'h30, 8'h01, 2'b10);
    rd(8'h30);
    `CHK({rd_resp, rd_data}, 34'h2_0000_0000);
  endtask
  task automatic t_ctrl();
    wr(CTRL, 8'h0A);
    cyc(2);
    `CHK(remote_command_enable, 1'b1);
    `CHK(fiber_tx_oe_n, 1'b1);
    wr(PAT, 8'h20);
    saw_phy <= 0;
    wr(CTRL, 8'h0B);
    cyc(3);
    `CHK(saw_phy, 1'b1);
    chk_rd(CTRL, 8'h0A);
    chk_rd(PAT, 8'h20);
    saw_sub <= 0;
    wr(CTRL, 8'h10);
    cyc(3);
    `CHK(saw_sub, 1'b1);
    chk_rd(CTRL, 8'h00);
    `CHK({remote_command_enable, fiber_tx_oe_n}, 2'b00);
  endtask
  task automatic t_link();
    wr(CTRL, 8'h04);
    fiber_link_down <= 1;
    cyc(6);
    `CHK(copper_tx_disable, 1'b0);
    do_reset(0, 1);
    chk_rd(CTRL, 8'h04);
    cyc(4);
    `CHK({copper_tx_disable, copper_led_off}, 2'b11);
    fiber_link_down <= 0;
    center_copper_link_down <= 1;
    cyc(6);
    `CHK({copper_tx_disable, copper_led_off}, 2'b11);
    wr(CTRL, 8'h01);
    cyc(6);
    `CHK({copper_tx_disable, copper_led_off}, 2'b00);
    center_copper_link_down <= 0;
    run(8'h03, 0);
    do_reset(1, 0);
    wr(`OLT_IDX_MODE_SETUP, 8'h00);
  endtask
  task automatic t_frames();
    for (int i = 0; i < 6; i++) wr(8'(`OLT_IDX_STATION_0 + i), 8'(16 + i));
    wr(`OLT_IDX_IRQ_MASK, 8'h00);
    stall <= 1;
    reply_mode <= 1;
    run(8'h02, 2);
    for (int i = 0; i < 6; i++) begin
      `CHK(hdr[i], i < 5 ? 8'(16 + i) : 8'h17);
      `CHK(hdr[6 + i], 8'(16 + i));
    end
    `CHK({hdr[12], hdr[13]}, 16'h0800);
    `CHK(frame_len, 60);
    stall <= 0;
    reply_mode <= 2;
    run(8'h01, 1);
    `CHK(hdr[5], 8'h16);
    chk_rd(BAD, 8'h02);
    chk_rd(LOST, 8'h01);
    `CHK(irq, 1'b0);
    wr(`OLT_IDX_IRQ_MASK, 8'h07);
    cyc(2);
    `CHK(irq, 1'b1);
    wr(`OLT_IDX_IRQ_STATUS, 8'h07);
    cyc(2);
    `CHK(irq, 1'b0);
    run(8'h00, 0);
    chk_rd(BAD, 8'h00);
    chk_rd(LOST, 8'h00);
  endtask
  task automatic t_patterns();
    logic [7:0] pc [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                           8'h40, 8'h80};
    logic [7:0] c;
    reply_mode <= 0;
    foreach (pc[i]) begin
      c = pc[i];
      wr(PAT, c);
      run(8'h01, 1);
      `CHK(frame_len, c inside {1, 4, 16, 64, 128} ? 1514 : 60);
      `CHK(hdr[0], c inside {4, 8, 64, 128} ? 8'hFF : 8'h10);
      `CHK({hdr[14], hdr[15]}, c[7] ? 16'hFF00 :
           (c > 8'h08 ? 16'h0F0F : 16'h55AA));
    end
  endtask
  task automatic t_sat();
    reply_mode <= 1;
    wr(PAT, 8'h00);
    repeat (3) run(8'h64, 100);
    chk_rd(BAD, 8'hFF);
    run(8'h65, 0);
  endtask
  initial begin
    t_power();
    t_ctrl();
    t_link();
    t_frames();
    t_patterns();
    t_sat();
    summarize();
  end
endmodule
